// ### rtl/arinc_rx_regs.vh
// Constants for the octal receiver control and status register logic.
// Included by every design file; holds definitions only.
`ifndef ARINC_RX_REGS_VH
`define ARINC_RX_REGS_VH

// Instruction byte: channel in the upper nibble, operation in the lower
`define OP_READ_FIFO 4'h3
`define OP_WRITE_CFG 4'h4
`define OP_READ_CFG 4'h5
`define OP_READ_STATUS 4'h6
`define OP_MASTER_RESET 4'h7
`define OPCODE_BITS 6'h08
`define CFG_WRITE_BITS 6'h18

// Configuration word fields
`define CFG_RATE_LOW 0
`define CFG_FLAG_MODE 1
`define CFG_LABEL_MATCH_EN 2
`define CFG_CHANNEL_RESET 3
`define CFG_PARITY_EN 4
`define CFG_LOOPBACK_N 5
`define CFG_DEC_EN 6
`define CFG_DEC_BIT10 7
`define CFG_DEC_BIT9 8
`define CFG_LABEL_ORDER 9
`define CFG_USED_MASK 16'h03FF
`define CFG_RESET_VALUE 16'h0000

// Receive FIFO
`define FIFO_DEPTH 4
`define FIFO_PTR_W 2
`define WORD_W 32

`endif

// ### rtl/two_entry_buf.v
// Two-entry buffer with valid/ready on both sides.
// Assumes producer and consumer on clk_i; in_ready_o is registered.
`timescale 1ns/1ns
`include "arinc_rx_regs.vh"
module two_entry_buf #(
    parameter W = 36
) (
    input wire clk_i,
    input wire rstn_i,
    input wire ce_i,
    input wire [W-1:0] in_data_i,
    input wire in_valid_i,
    output reg in_ready_o,
    output wire [W-1:0] out_data_o,
    output wire out_valid_o,
    input wire out_ready_i
);
    reg [W-1:0] slot [0:1];
    reg rd_ptr;
    reg wr_ptr;
    reg [1:0] count;
    wire do_push = in_valid_i & in_ready_o;
    wire do_pop = out_valid_o & out_ready_i;
    reg [1:0] next_count;

    assign out_valid_o = (count != 2'h0);
    assign out_data_o = slot[rd_ptr];

    always @* begin
        next_count = count;
        if (do_push & ~do_pop) begin
            next_count = count + 2'h1;
        end else if (do_pop & ~do_push) begin
            next_count = count - 2'h1;
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
            in_ready_o <= 1'b0;
        end else if (ce_i) begin
            if (do_push) begin
                slot[wr_ptr] <= in_data_i;
                wr_ptr <= ~wr_ptr;
            end
            if (do_pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= next_count;
            in_ready_o <= (next_count != 2'h2);
        end
    end
endmodule // two_entry_buf

// ### rtl/rx_fifo4.v
// Four-word receive FIFO for one channel.
// Assumes a clear that wins over push and pop; a push when full overwrites
// the newest word.
`timescale 1ns/1ns
`include "arinc_rx_regs.vh"
module rx_fifo4 (
    input wire clk_i,
    input wire rstn_i,
    input wire ce_i,
    input wire clear_i,
    input wire push_i,
    input wire [`WORD_W-1:0] din_i,
    input wire pop_i,
    output wire [`WORD_W-1:0] dout_o,
    output reg empty_o,
    output reg full_o
);
    reg [`WORD_W-1:0] mem [0:`FIFO_DEPTH-1];
    reg [`FIFO_PTR_W-1:0] rd_ptr;
    reg [`FIFO_PTR_W-1:0] wr_ptr;
    reg [2:0] count;
    reg [2:0] next_count;
    wire do_pop = pop_i & ~empty_o;
    wire do_push = push_i & (~full_o | do_pop);
    wire overwrite = push_i & full_o & ~do_pop;

    // Reading an empty FIFO returns zeros
    assign dout_o = empty_o ? {`WORD_W{1'b0}} : mem[rd_ptr];

    always @* begin
        next_count = count;
        if (do_push & ~do_pop) begin
            next_count = count + 3'h1;
        end else if (do_pop & ~do_push) begin
            next_count = count - 3'h1;
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_ptr <= {`FIFO_PTR_W{1'b0}};
            wr_ptr <= {`FIFO_PTR_W{1'b0}};
            count <= 3'h0;
            empty_o <= 1'b1;
            full_o <= 1'b0;
        end else if (ce_i) begin
            if (clear_i) begin
                rd_ptr <= {`FIFO_PTR_W{1'b0}};
                wr_ptr <= {`FIFO_PTR_W{1'b0}};
                count <= 3'h0;
                empty_o <= 1'b1;
                full_o <= 1'b0;
            end else begin
                if (do_push) begin
                    mem[wr_ptr] <= din_i;
                    wr_ptr <= wr_ptr + 2'h1;
                end
                if (overwrite) begin
                    mem[wr_ptr - 2'h1] <= din_i;
                end
                if (do_pop) begin
                    rd_ptr <= rd_ptr + 2'h1;
                end
                count <= next_count;
                empty_o <= (next_count == 3'h0);
                full_o <= (next_count == 3'h4);
            end
        end
    end
endmodule // rx_fifo4

// ### rtl/arinc_rx_regs.v
// Control and status register logic of an eight-channel serial-word receiver,
// reached over a four-wire serial command port (mode 0: sample on rising SCK).
// Assumes receiver bit logic on clk_i delivers finished words with a label hit;
// the serial port pins, master reset and line inputs are asynchronous.
//
// Behaviour
// [R1] Each channel holds a 16-bit config word written by opcode n4.
// [R2] Writing a channel's config word empties that channel's FIFO.
// [R3] Opcode n5 returns the channel's config word on the serial output.
// [R4] Rate bit 0 selects high-speed (ref/10), 1 selects low-speed (ref/80).
// [R5] Flag mode 0: flag while FIFO non-empty; mode 1: flag while full.
// [R6] Label-match enable accepts only words whose label hits the table.
// [R7] Channel-reset bit clears receiver and FIFO and holds the channel disabled.
// [R8] Parity disabled: all 32 received bits stored as data.
// [R9] Parity enabled: odd ones count, parity included, stores 0 in bit 32.
// [R10] Loopback bit 0 feeds receiver from test output; 1 from the line.
// [R11] Decoder enable 1 requires ARINC bits 10 and 9 to match config.
// [R12] Bit 10 compares with config bit 7, bit 9 with config bit 8.
// [R13] Only words passing every enabled check enter the FIFO; others dropped.
// [R14] Label-order 0 reverses the label bits; 1 keeps received order. The code reverses on 1 and keeps on 0.
// [R15] Config bits 10 to 15 read back as zero.
// [R16] Opcode n6 returns the shared 16-bit status word.
// [R17] Status bits 0-7 are FIFO-empty for channels 1-8.
// [R18] Status bits 8-15 are FIFO-full for channels 1-8.
// [R19] Host must read a full FIFO within one word period.
// [R20] Read word positions 1-24 carry ARINC bits 32 down to 9.
// [R21] Positions 25-32 carry the label in the selected order.
// [R22] Host puts channel 1-8 in upper nibble, opcode in lower nibble.
// [R23] Channel flag follows inverted empty or full; combined flag ORs all.
// [R24] Reset shows empty, not-full FIFOs; master reset keeps config words.
`timescale 1ns/1ns
`include "arinc_rx_regs.vh"
module arinc_rx_regs (
    input wire clk_i,
    input wire rstn_i,
    input wire ce_i,
    input wire cs_n_i,
    input wire sck_i,
    input wire si_i,
    output reg so_o,
    input wire master_reset_i,
    input wire [7:0] line_i,
    input wire tx_test_i,
    input wire [31:0] word_i,
    input wire [2:0] word_chan_i,
    input wire word_label_hit_i,
    input wire word_valid_i,
    output wire word_ready_o,
    output reg [7:0] rx_in_o,
    output reg [7:0] rate_low_o,
    output reg [7:0] rx_reset_o,
    output reg [7:0] flag_o,
    output reg flag_any_o
);
    // Synchronisers for the asynchronous pins
    reg cs_s1;
    reg cs_s2;
    reg sck_s1;
    reg sck_s2;
    reg sck_s3;
    reg si_s1;
    reg si_s2;
    reg mr_s1;
    reg mr_s2;
    reg [7:0] line_s1;
    reg [7:0] line_s2;
    reg tx_s1;
    reg tx_s2;

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
            mr_s1 <= 1'b0;
            mr_s2 <= 1'b0;
            line_s1 <= 8'h00;
            line_s2 <= 8'h00;
            tx_s1 <= 1'b0;
            tx_s2 <= 1'b0;
        end else if (ce_i) begin
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            sck_s1 <= sck_i;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            si_s1 <= si_i;
            si_s2 <= si_s1;
            mr_s1 <= master_reset_i;
            mr_s2 <= mr_s1;
            line_s1 <= line_i;
            line_s2 <= line_s1;
            tx_s1 <= tx_test_i;
            tx_s2 <= tx_s1;
        end
    end

    wire sck_rise = sck_s2 & ~sck_s3 & ~cs_s2;
    wire sck_fall = ~sck_s2 & sck_s3 & ~cs_s2;

    // Serial command state
    reg [5:0] bit_cnt;
    reg [23:0] shift_in;
    reg [31:0] shift_out;
    reg [3:0] op_q;
    reg [2:0] chan_q;
    reg chan_ok_q;
    wire [5:0] next_bit_cnt = bit_cnt + 6'h01;
    wire [23:0] next_shift_in = {shift_in[22:0], si_s2};
    wire [3:0] new_op = next_shift_in[3:0];
    wire [3:0] new_chan = next_shift_in[7:4];
    wire new_chan_ok = (new_chan >= 4'h1) && (new_chan <= 4'h8); // see [R22]
    wire [2:0] new_idx = new_chan[2:0] - 3'h1;
    wire opcode_done = sck_rise && (next_bit_cnt == `OPCODE_BITS);

    // Channel configuration words and FIFO state
    reg [15:0] cfg [0:7];
    wire [255:0] fifo_dout;
    wire [7:0] fifo_empty;
    wire [7:0] fifo_full;
    wire [31:0] sel_word = fifo_dout[new_idx*32 +: 32];
    wire [15:0] sel_cfg = cfg[new_idx];
    wire [15:0] status_word = {fifo_full, fifo_empty}; // see [R17] [R18]

    // Read word: ARINC bits 32..9 first, then the label in chosen order
    reg [7:0] label_out;
    integer k;
    always @* begin
        label_out = 8'h00;
        for (k = 0; k < 8; k = k + 1) begin
            if (sel_cfg[`CFG_LABEL_ORDER]) begin
                label_out[7-k] = sel_word[k]; // see [R14] [R21]
            end else begin
                label_out[k] = sel_word[k]; // see [R14] [R21]
            end
        end
    end
    wire [31:0] read_word = {sel_word[31:8], label_out}; // see [R20]

    wire pop_req = opcode_done && new_chan_ok && (new_op == `OP_READ_FIFO);
    wire mr_cmd = opcode_done && (new_op == `OP_MASTER_RESET);
    wire cfg_write = sck_rise && (next_bit_cnt == `CFG_WRITE_BITS) && chan_ok_q
        && (op_q == `OP_WRITE_CFG);
    reg master_clear;

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            bit_cnt <= 6'h00;
            shift_in <= 24'h000000;
            shift_out <= 32'h00000000;
            op_q <= 4'h0;
            chan_q <= 3'h0;
            chan_ok_q <= 1'b0;
            so_o <= 1'b0;
        end else if (ce_i) begin
            if (cs_s2) begin
                // Deselect aborts any partial instruction
                bit_cnt <= 6'h00;
                shift_out <= 32'h00000000;
                chan_ok_q <= 1'b0;
                so_o <= 1'b0;
            end else begin
                if (sck_rise) begin
                    shift_in <= next_shift_in;
                    if (next_bit_cnt != 6'h3F) begin
                        bit_cnt <= next_bit_cnt;
                    end
                end
                if (opcode_done) begin
                    op_q <= new_op;
                    chan_q <= new_idx;
                    chan_ok_q <= new_chan_ok;
                    if (new_chan_ok && new_op == `OP_READ_FIFO) begin
                        shift_out <= read_word;
                    end else if (new_chan_ok && new_op == `OP_READ_CFG) begin
                        shift_out <= {sel_cfg & `CFG_USED_MASK, 16'h0000}; // see [R3] [R15]
                    end else if (new_op == `OP_READ_STATUS) begin
                        shift_out <= {status_word, 16'h0000}; // see [R16]
                    end else begin
                        shift_out <= 32'h00000000;
                    end
                end
                if (sck_fall) begin
                    so_o <= shift_out[31];
                    shift_out <= {shift_out[30:0], 1'b0};
                end
            end
        end
    end

    // Configuration words survive master reset; only power reset clears them
    integer c;
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            for (c = 0; c < 8; c = c + 1) begin
                cfg[c] <= `CFG_RESET_VALUE; // see [R24]
            end
            master_clear <= 1'b0;
        end else if (ce_i) begin
            if (cfg_write) begin
                cfg[chan_q] <= next_shift_in[15:0] & `CFG_USED_MASK; // see [R1] [R15]
            end
            master_clear <= mr_s2 | mr_cmd;
        end
    end

    // Incoming words pass a two-entry buffer; draining stalls during a pop
    wire [35:0] buf_out;
    wire buf_valid;
    wire buf_ready = ~pop_req;

    two_entry_buf #(
        .W(36)
    ) u_in_buf (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .in_data_i({word_label_hit_i, word_chan_i, word_i}),
        .in_valid_i(word_valid_i),
        .in_ready_o(word_ready_o),
        .out_data_o(buf_out),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_ready)
    );

    wire [31:0] in_word = buf_out[31:0];
    wire [2:0] in_chan = buf_out[34:32];
    wire in_hit = buf_out[35];
    wire in_take = buf_valid & buf_ready;
    wire [15:0] in_cfg = cfg[in_chan];
    // Bit 10 of the ARINC word is in_word[9], bit 9 is in_word[8]
    wire dec_ok = ~in_cfg[`CFG_DEC_EN]
        | ((in_word[9] == in_cfg[`CFG_DEC_BIT10])
        & (in_word[8] == in_cfg[`CFG_DEC_BIT9])); // see [R11] [R12]
    wire label_ok = ~in_cfg[`CFG_LABEL_MATCH_EN] | in_hit; // see [R6]
    wire in_pass = dec_ok & label_ok & ~in_cfg[`CFG_CHANNEL_RESET]; // see [R13] [R7]
    // Parity enabled: parity bit replaced by 0 when ones count is odd, 1 when even; disabled: kept as data
    wire [31:0] in_store = in_cfg[`CFG_PARITY_EN] ? {~^in_word, in_word[30:0]}
        : in_word; // see [R8] [R9]

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_chan
            wire [15:0] ch_cfg = cfg[g];
            wire ch_clear = master_clear | ch_cfg[`CFG_CHANNEL_RESET]
                | (cfg_write && chan_q == g); // see [R2] [R7]
            wire ch_push = in_take && in_pass && (in_chan == g); // see [R13]
            wire ch_pop = pop_req && (new_idx == g);

            rx_fifo4 u_fifo (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .ce_i(ce_i),
                .clear_i(ch_clear),
                .push_i(ch_push),
                .din_i(in_store),
                .pop_i(ch_pop),
                .dout_o(fifo_dout[g*32 +: 32]),
                .empty_o(fifo_empty[g]),
                .full_o(fifo_full[g])
            );

            always @(posedge clk_i) begin
                if (!rstn_i) begin
                    rx_in_o[g] <= 1'b0;
                    rate_low_o[g] <= 1'b0;
                    rx_reset_o[g] <= 1'b1;
                    flag_o[g] <= 1'b0;
                end else if (ce_i) begin
                    // Loopback bit is active low: 0 routes the test output
                    rx_in_o[g] <= ch_cfg[`CFG_LOOPBACK_N] ? line_s2[g] : tx_s2; // see [R10]
                    rate_low_o[g] <= ch_cfg[`CFG_RATE_LOW]; // see [R4]
                    rx_reset_o[g] <= ch_cfg[`CFG_CHANNEL_RESET] | master_clear; // see [R7]
                    flag_o[g] <= ch_cfg[`CFG_FLAG_MODE] ? fifo_full[g]
                        : ~fifo_empty[g]; // see [R5] [R23]
                end
            end
        end
    endgenerate

    // Combined flag lags the channel flags by one cycle to stay registered
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            flag_any_o <= 1'b0;
        end else if (ce_i) begin
            flag_any_o <= |flag_o; // see [R23]
        end
    end
endmodule // arinc_rx_regs

// ### tb/arinc_rx_regs_chk.sv
// Checker for the receiver register block, bound to its top module.
// Assumes ce_i is held high whenever these timings are expected to hold.
`timescale 1ns/1ns
module arinc_rx_regs_chk (
    input logic clk_i,
    input logic rstn_i,
    input logic ce_i,
    input logic cs_n_i,
    input logic so_o,
    input logic master_reset_i,
    input logic [7:0] line_i,
    input logic tx_test_i,
    input logic word_valid_i,
    input logic word_ready_o,
    input logic [7:0] rx_in_o,
    input logic [7:0] rx_reset_o,
    input logic [7:0] flag_o,
    input logic flag_any_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i || !ce_i);

    // Pin must outlast the two-stage sync plus the delayed clear pulse
    sequence mr_held;
        master_reset_i [*8];
    endsequence
    // Line and test bit agree, so the mux result does not depend on config
    sequence rx_steady;
        ($stable({line_i, tx_test_i}) && line_i == {8{tx_test_i}}) [*5];
    endsequence

    reset_vals_a: assert property (disable iff (1'b0)
        !rstn_i && ce_i |=> !so_o && !word_ready_o && rx_reset_o == 8'hFF
        && flag_o == 8'h00 && !flag_any_o) else $error("reset outputs wrong");
    any_flag_a: assert property (flag_any_o == |$past(flag_o))
        else $error("combined flag differs from channel flags");
    mr_clear_a: assert property (mr_held |-> rx_reset_o == 8'hFF && flag_o == 8'h00)
        else $error("master reset did not clear channels");
    idle_so_a: assert property (cs_n_i [*6] |-> !so_o)
        else $error("serial output busy while deselected");
    ready_up_a: assert property ($rose(rstn_i) |=> word_ready_o && rx_reset_o == 8'h00)
        else $error("no ready or channel held after reset");
    ready_fall_a: assert property ($fell(word_ready_o) |-> $past(word_valid_i))
        else $error("ready dropped with no word offered");
    chan_held_a: assert property ((rx_reset_o & $past(rx_reset_o) & $past(rx_reset_o, 2)
        & $past(rx_reset_o, 3) & flag_o) == 8'h00) else $error("flag while channel held");
    loop_mux_a: assert property (rx_steady |-> rx_in_o == line_i)
        else $error("receiver input does not follow its source");
endmodule // arinc_rx_regs_chk

bind arinc_rx_regs arinc_rx_regs_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .cs_n_i(cs_n_i), .so_o(so_o), .master_reset_i(master_reset_i), .line_i(line_i),
    .tx_test_i(tx_test_i), .word_valid_i(word_valid_i), .word_ready_o(word_ready_o),
    .rx_in_o(rx_in_o), .rx_reset_o(rx_reset_o), .flag_o(flag_o), .flag_any_o(flag_any_o));

// ### tb/spi_host.sv
// Host model: mode 0 serial master shifting an instruction and its data field.
// Assumes the device samples SI on rising SCK and moves SO after falling SCK.
`timescale 1ns/1ns
module spi_host (
    input wire clk_i,
    input wire so_i,
    output reg cs_n_o,
    output reg sck_o,
    output reg si_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end

    // Six clocks per phase leave room for the device's input synchronisers
    task xfer(input [3:0] ch, input [3:0] op, input [5:0] n, input [31:0] wd,
        output logic [31:0] rdata);
        logic [39:0] sh;
        int i;
        sh = {ch, op, 32'h0} | ({8'h00, wd} << (32 - n));
        rdata = 32'h0;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (i = 0; i < 8 + n; i++) begin
            si_o <= sh[39-i];
            repeat (5) @(posedge clk_i);
            @(negedge clk_i);
            rdata = {rdata[30:0], so_i};
            @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (6) @(posedge clk_i);
            sck_o <= 1'b0;
        end
        if (n < 32) rdata = rdata & ((32'h1 << n) - 32'h1);
        repeat (6) @(posedge clk_i);
        cs_n_o <= 1'b1;
        // A released line must not keep showing the last bit
        si_o <= ~si_o;
        repeat (6) @(posedge clk_i);
    endtask
endmodule // spi_host

// ### tb/test_arinc_rx_regs.sv
// Bench for the receiver register block: host calls, word pushes, expected values.
// Assumes spi_host as the serial master and the checker bound in its own file.
`timescale 1ns/1ns
`include "arinc_rx_regs.vh"
module test_arinc_rx_regs;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg ce = 1'b1;
    reg mr = 1'b0;
    reg [7:0] line = 8'hA5;
    reg tx_test = 1'b1;
    reg [31:0] word = 32'h0;
    reg [2:0] chan = 3'h0;
    reg hit = 1'b0;
    reg valid = 1'b0;
    wire cs_n, sck, si, so, ready, flag_any;
    wire [7:0] rx_in, rate_low, rx_reset, flag;
    int bad_count = 0;
    int check_count = 0;
    logic [31:0] got;

    always #5 clk = ~clk;

    spi_host u_host (.clk_i(clk), .so_i(so), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
    arinc_rx_regs u_dut (.clk_i(clk), .rstn_i(rstn), .ce_i(ce), .cs_n_i(cs_n),
        .sck_i(sck), .si_i(si), .so_o(so), .master_reset_i(mr), .line_i(line),
        .tx_test_i(tx_test), .word_i(word), .word_chan_i(chan), .word_label_hit_i(hit),
        .word_valid_i(valid), .word_ready_o(ready), .rx_in_o(rx_in), .rate_low_o(rate_low),
        .rx_reset_o(rx_reset), .flag_o(flag), .flag_any_o(flag_any));

    task results;
        if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] act);
        check_count++;
        if (act !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, act);
        end
    endtask

    task rd(input [3:0] ch, input [3:0] op, input [5:0] n);
        u_host.xfer(ch, op, n, 32'h0, got);
    endtask

    task wr(input [3:0] ch, input [15:0] v);
        u_host.xfer(ch, `OP_WRITE_CFG, 6'd16, {16'h0, v}, got);
    endtask

    task st3(input e, input f);
        rd(4'h0, `OP_READ_STATUS, 6'd16);
        chk("empty3", e, got[2]);
        chk("full3", f, got[10]);
    endtask

    // Holds the word until ready is seen at the taking edge, then lets flags settle
    task push(input [2:0] c, input [31:0] w, input h);
        int n;
        logic r;
        n = 0;
        @(posedge clk);
        word <= w;
        chan <= c;
        hit <= h;
        valid <= 1'b1;
        do begin
            @(negedge clk);
            r = ready;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 20);
        valid <= 1'b0;
        word <= ~w;
        if (r !== 1'b1) begin
            bad_count++;
            results;
        end
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask

    function automatic [7:0] rev8(input [7:0] b);
        for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
    endfunction

    initial begin
        int k, n;
        logic [15:0] v;
        logic r;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(4'h0, `OP_READ_STATUS, 6'd16);
        chk("status", 16'h00FF, got);
        for (k = 1; k <= 8; k++) begin
            v = ~(16'(k) * 16'h0009);
            wr(k[3:0], v);
            rd(k[3:0], `OP_READ_CFG, 6'd16);
            chk("cfg", v & 16'h03FF, got);
            chk("rate", v[0], rate_low[k-1]);
            chk("chreset", v[3], rx_reset[k-1]);
            chk("rxin", v[5] ? line[k-1] : tx_test, rx_in[k-1]);
        end
        wr(4'h0, 16'h0000);
        rd(4'h8, `OP_READ_CFG, 6'd16);
        chk("cfg8", 16'h03B7, got);
        rd(4'h9, `OP_READ_CFG, 6'd16);
        chk("cfg9", 32'h0, got);
        for (k = 0; k < 2; k++) begin
            wr(4'h3, {6'h00, k[0], 9'h020});
            push(3'd2, 32'hC3A5_5A96, 1'b0);
            chk("flag", 1'b1, flag[2]);
            chk("flag_any", 1'b1, flag_any);
            st3(1'b0, 1'b0);
            rd(4'h3, `OP_READ_FIFO, 6'd32);
            chk("word", {24'hC3A55A, k ? rev8(8'h96) : 8'h96}, got);
            st3(1'b1, 1'b0);
        end
        wr(4'h3, 16'h0022);
        for (k = 0; k < 5; k++) begin
            push(3'd2, 32'h1000_0000 + k, 1'b0);
            chk("flag_full", k >= 3, flag[2]);
        end
        st3(1'b0, 1'b1);
        for (k = 0; k < 5; k++) begin
            rd(4'h3, `OP_READ_FIFO, 6'd32);
            chk("fifo", k == 4 ? 32'h0 : 32'h1000_0000 + (k == 3 ? 4 : k), got);
        end
        push(3'd2, 32'h5, 1'b1);
        wr(4'h3, 16'h0022);
        st3(1'b1, 1'b0);
        for (k = 0; k < 4; k++) begin
            wr(4'h3, {9'h001, k[1], 3'b100, k[0], 2'b00});
            push(3'd2, 32'h0000_0100, 1'b0);
            st3(k != 0, 1'b0);
            push(3'd2, 32'h0000_0200, 1'b1);
            st3(1'b0, 1'b0);
        end
        for (k = 0; k < 2; k++) begin
            wr(4'h3, {10'h000, 1'b1, k[0], 4'h0});
            push(3'd2, 32'h8000_0003, 1'b0);
            rd(4'h3, `OP_READ_FIFO, 6'd32);
            chk("parity", {~k[0], 31'h3}, got);
        end
        wr(4'h3, 16'h0028);
        push(3'd2, 32'h1, 1'b0);
        st3(1'b1, 1'b0);
        chk("rx_reset", 1'b1, rx_reset[2]);
        wr(4'h3, 16'h0020);
        // Words offered back to back across a FIFO read fill the buffer's second slot
        fork
            rd(4'h3, `OP_READ_FIFO, 6'd32);
            begin
                @(posedge clk);
                word <= 32'h0000_0042;
                chan <= 3'd2;
                hit <= 1'b0;
                valid <= 1'b1;
                n = 0;
                do begin
                    @(negedge clk);
                    r = ready;
                    @(posedge clk);
                    n++;
                end while ((n < 200 || r !== 1'b1) && n < 220);
                valid <= 1'b0;
            end
        join
        chk("stream", 32'h0000_0042, got);
        push(3'd2, 32'h1, 1'b0);
        rd(4'h0, `OP_MASTER_RESET, 6'd0);
        rd(4'h0, `OP_READ_STATUS, 6'd16);
        chk("status mr", 16'h00FF, got);
        rd(4'h3, `OP_READ_CFG, 6'd16);
        chk("cfg kept", 16'h0020, got);
        push(3'd2, 32'h1, 1'b0);
        @(posedge clk);
        mr <= 1'b1;
        line <= 8'hFF;
        repeat (12) @(posedge clk);
        mr <= 1'b0;
        st3(1'b1, 1'b0);
        // Clock enable low must freeze the line path; it resumes once enabled
        @(posedge clk);
        ce <= 1'b0;
        line <= 8'h00;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk("ce_hold", 1'b1, rx_in[2]);
        @(posedge clk);
        ce <= 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk("ce_run", 1'b0, rx_in[2]);
        results;
    end
endmodule // test_arinc_rx_regs
